// ---- src/rtd_data_format_map.sv ----
// How it works
// - a point in binary format reports a signed count in tenths of a degree.
// - a point in bcd format reports whole degrees with one degree resolution.
// - bcd words carry the sign in bit 15 and a bcd magnitude clamped to 7999.
// - binary words are two's complement clamped to -32767 through +32767.
// - the format is chosen per point in the format select word and resets to bcd.
// - per-point words map points 1 to 8 on bits 0 to 7; only the status word maps them again on bits 8 to 15.
// - status flags on bits 8 to 15 are driven only by the block, bits 0 to 7 mirror the format select word, 1 meaning active.
// - every map word is 16 bits holding one value, a set of point bits or the three error flags.
// - bits 0 to 7 of word 29 pick celsius or fahrenheit for each point.
// - 2-word mode uses the intelligent read/write port, 4-word mode the i/o word port.
// - the map has read-only data and status words and writable parameter words.
// - readings are linearised with alpha 0.00385 platinum, 0.00672 nickel, 0.00427 copper.
// - parameter words are taken in unsigned bcd regardless of the point format.
// - the mode jumper selects 2-word mode in its upper and 4-word mode in its lower position.
`timescale 1ns/1ps
`default_nettype none
module rtd_data_format_map #(
    parameter int POINT_COUNT = rtd_format_pkg::POINTS,
    parameter int FIFO_WORDS  = rtd_format_pkg::FIFO_DEPTH
) (
    input  wire logic                            clk_sys,
    input  wire logic                            resetn,
    input  wire rtd_format_pkg::conv_sample_type conv_sample,
    input  wire logic                            conv_valid,
    output var  logic                            conv_ready,
    input  wire logic                            mode_jumper_upper,
    input  wire rtd_format_pkg::mm_req_type      iio_req,
    output var  logic [15:0]                     iio_rdata,
    output var  logic                            iio_rvalid,
    input  wire rtd_format_pkg::mm_req_type      ioword_req,
    output var  logic [15:0]                     ioword_rdata,
    output var  logic                            ioword_rvalid,
    output var  logic                            two_word_mode
);
    import rtd_format_pkg::*;

    typedef enum {ST_IDLE, ST_LIN, ST_SCALE, ST_FORMAT} step_type;

    function automatic logic [15:0] to_bcd(input logic [13:0] bin);
        logic [15:0] bcd;
        int          i;
        bcd = '0;
        for (i = 13; i >= 0; i--)
        begin
            if (bcd[3:0] > 4'd4)
                bcd[3:0] = bcd[3:0] + 4'd3;
            if (bcd[7:4] > 4'd4)
                bcd[7:4] = bcd[7:4] + 4'd3;
            if (bcd[11:8] > 4'd4)
                bcd[11:8] = bcd[11:8] + 4'd3;
            if (bcd[15:12] > 4'd4)
                bcd[15:12] = bcd[15:12] + 4'd3;
            bcd = {bcd[14:0], bin[i]};
        end
        return bcd;
    endfunction : to_bcd

    function automatic logic is_bcd(input logic [15:0] w);
        return (w[3:0] < 4'd10) && (w[7:4] < 4'd10) && (w[11:8] < 4'd10) && (w[15:12] < 4'd10);
    endfunction : is_bcd

    function automatic logic in_range(input logic [6:0] a, input logic [6:0] base);
        return (a >= base) && (a < base + 7'(POINT_COUNT));
    endfunction : in_range

    // mode jumper crosses in from a pin: three flops, act once the last two agree
    logic jmp_s1_q;
    logic jmp_s2_q;
    logic jmp_s3_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            jmp_s1_q      <= 1'b1;
            jmp_s2_q      <= 1'b1;
            jmp_s3_q      <= 1'b1;
            two_word_mode <= 1'b1;
        end
        else
        begin
            jmp_s1_q <= mode_jumper_upper;
            jmp_s2_q <= jmp_s1_q;
            jmp_s3_q <= jmp_s2_q;
            if (jmp_s2_q == jmp_s3_q)
                two_word_mode <= jmp_s3_q;
        end
    end

    // only the port that matches the mode is served
    mm_req_type req;
    assign req = two_word_mode ? iio_req : ioword_req;

    // sample buffer between converter and formatter
    conv_sample_type fifo_out;
    logic            fifo_valid;
    logic            fifo_pop;

    sample_fifo #(
        .WIDTH ($bits(conv_sample_type)),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_data   (conv_sample),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // map storage
    logic [15:0] data_q [POINT_COUNT];
    logic [15:0] param_q [POINT_COUNT];
    logic [7:0]  format_q;
    logic [7:0]  scale_q;
    logic [7:0]  fresh_q;
    logic [2:0]  err_q;

    // formatter pipeline registers
    step_type            step_q;
    logic [2:0]          pt_q;
    logic                fmt_bin_q;
    logic                fmt_f_q;
    logic signed [33:0]  prod_q;
    logic signed [19:0]  temp_q;

    // access decode
    logic       data_hit;
    logic       param_hit;
    logic       fmt_hit;
    logic       scale_hit;
    logic       stat_hit;
    logic       err_hit;
    logic       ro_hit;
    logic       mapped;
    logic [2:0] data_idx;
    logic [2:0] param_idx;

    assign data_hit  = in_range(req.addr, DATA_BASE_ADDR);
    assign param_hit = in_range(req.addr, PARAM_BASE_ADDR);
    assign fmt_hit   = (req.addr == FORMAT_SEL_ADDR);
    assign scale_hit = (req.addr == SCALE_SEL_ADDR);
    assign stat_hit  = (req.addr == STATUS_FLAG_ADDR);
    assign err_hit   = (req.addr == ERROR_FLAG_ADDR);
    assign ro_hit    = data_hit || stat_hit || err_hit;
    assign mapped    = ro_hit || param_hit || fmt_hit || scale_hit;
    assign data_idx  = 3'(req.addr - DATA_BASE_ADDR);
    assign param_idx = 3'(req.addr - PARAM_BASE_ADDR);

    logic [15:0] status_word;
    logic [15:0] error_word;
    logic [15:0] rd_word;

    // flags: low byte = point in binary, high byte = point holds unread data
    assign status_word = {fresh_q, format_q};
    assign error_word  = {13'h0000, err_q};
    assign rd_word = data_hit  ? data_q[data_idx] :
                     param_hit ? param_q[param_idx] :
                     fmt_hit   ? {8'h00, format_q} :
                     scale_hit ? {8'h00, scale_q} :
                     stat_hit  ? status_word :
                     err_hit   ? error_word : 16'h0000;

    // reads and writes win the cycle; the formatter waits, letting the buffer fill
    logic busy;
    logic commit;
    assign busy     = req.rd || req.wr;
    assign fifo_pop = (step_q == ST_IDLE) && fifo_valid && !busy;
    assign commit   = (step_q == ST_FORMAT) && !busy;

    // linearise: gain is 16*10/alpha so delta (q15 of R/R0 - 1) becomes tenths
    logic [16:0]         gain;
    logic signed [19:0]  tenths_c;
    logic signed [19:0]  temp_f;
    logic signed [19:0]  temp_sel;
    logic signed [38:0]  f_prod;

    assign gain = (fifo_out.sensor == SENSOR_NI) ? GAIN_NI :
                  (fifo_out.sensor == SENSOR_CU) ? GAIN_CU : GAIN_PT;
    assign tenths_c = 20'(prod_q >>> GAIN_SHIFT);
    assign f_prod   = $signed(tenths_c * 20'sd9) * $signed({1'b0, DIV5_MUL});
    assign temp_f   = 20'(f_prod >>> DIV5_SHIFT) + F_OFFSET;
    assign temp_sel = fmt_f_q ? temp_f : tenths_c;

    // binary word: tenths, clamped symmetric
    logic [15:0] bin_word;
    assign bin_word = (temp_q > BIN_MAX) ? 16'(BIN_MAX) :
                      (temp_q < BIN_MIN) ? 16'(BIN_MIN) : temp_q[15:0];

    // bcd word: rounded whole degrees, sign in bit 15
    logic        neg;
    logic [19:0] mag;
    logic [36:0] deg_prod;
    logic [17:0] deg_raw;
    logic [13:0] deg;
    logic [15:0] deg_bcd;
    logic [15:0] bcd_word;

    assign neg      = temp_q[19];
    assign mag      = neg ? 20'(-temp_q) : 20'(temp_q);
    assign deg_prod = (mag + 20'd5) * DIV5_MUL;
    assign deg_raw  = 18'(deg_prod >> DIV10_SHIFT);
    assign deg      = (deg_raw > 18'(BCD_MAX)) ? BCD_MAX : deg_raw[13:0];
    assign deg_bcd  = to_bcd(deg);
    // no minus zero: a value that rounds to 0 reports a clear sign bit
    assign bcd_word = {neg && (deg != '0), deg_bcd[14:0]};

    logic [15:0] out_word;
    assign out_word = fmt_bin_q ? bin_word : bcd_word;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            step_q    <= ST_IDLE;
            pt_q      <= '0;
            fmt_bin_q <= 1'b0;
            fmt_f_q   <= 1'b0;
            prod_q    <= '0;
            temp_q    <= '0;
        end
        else
        begin
            case (step_q)
                ST_IDLE:
                begin
                    if (fifo_pop)
                    begin
                        pt_q   <= fifo_out.point;
                        prod_q <= $signed(fifo_out.delta) * $signed({1'b0, gain});
                        step_q <= ST_LIN;
                    end
                end
                ST_LIN:
                begin
                    // format and scale latched per sample so one word uses one setting
                    fmt_bin_q <= format_q[pt_q];
                    fmt_f_q   <= scale_q[pt_q];
                    step_q    <= ST_SCALE;
                end
                ST_SCALE:
                begin
                    temp_q <= temp_sel;
                    step_q <= ST_FORMAT;
                end
                ST_FORMAT:
                begin
                    if (commit)
                        step_q <= ST_IDLE;
                end
                default:
                    step_q <= ST_IDLE;
            endcase
        end
    end

    // map writes and read answers
    // a read in the same cycle as a write returns the word as it stood before
    logic wr_ok;
    logic wr_bad_bcd;
    logic fmt_wr;
    logic scale_wr;
    logic param_wr;
    logic data_rd;
    logic err_rd;
    logic ro_wr;
    logic stray_acc;
    assign wr_ok      = req.wr && !ro_hit && mapped;
    assign wr_bad_bcd = req.wr && param_hit && !is_bcd(req.wdata);
    // strobes of the selected port, named so the register process stays short
    assign fmt_wr     = wr_ok && fmt_hit;
    assign scale_wr   = wr_ok && scale_hit;
    assign param_wr   = wr_ok && param_hit && !wr_bad_bcd;
    assign data_rd    = req.rd && data_hit;
    assign err_rd     = req.rd && err_hit;
    assign ro_wr      = req.wr && ro_hit;
    assign stray_acc  = busy && !mapped;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            format_q <= FORMAT_SEL_RESET[7:0];
            scale_q  <= SCALE_SEL_RESET[7:0];
            fresh_q  <= '0;
            err_q    <= '0;
            for (int i = 0; i < POINT_COUNT; i++)
            begin
                data_q[i]  <= DATA_RESET;
                param_q[i] <= PARAM_RESET;
            end
        end
        else
        begin
            // whole word replaced in one edge, and never while a read is served
            if (commit)
                data_q[pt_q] <= out_word;
            // user bits: 1 selects binary / fahrenheit; the controller keeps a point's values consistent
            if (fmt_wr)
                format_q <= req.wdata[7:0];
            if (scale_wr)
                scale_q <= req.wdata[7:0];
            if (param_wr)
                param_q[param_idx] <= req.wdata;
            // fresh flag: set on new data wins over clear on read
            for (int i = 0; i < POINT_COUNT; i++)
            begin
                if (commit && pt_q == 3'(i))
                    fresh_q[i] <= 1'b1;
                else if (data_rd && data_idx == 3'(i))
                    fresh_q[i] <= 1'b0;
            end
            // error flags clear on reading them; a new error in that cycle still sticks
            err_q[ERR_RO_WRITE] <= ro_wr || (err_q[ERR_RO_WRITE] && !err_rd);
            err_q[ERR_NOT_BCD]  <= wr_bad_bcd || (err_q[ERR_NOT_BCD] && !err_rd);
            err_q[ERR_UNMAPPED] <= stray_acc || (err_q[ERR_UNMAPPED] && !err_rd);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            iio_rdata     <= '0;
            iio_rvalid    <= 1'b0;
            ioword_rdata  <= '0;
            ioword_rvalid <= 1'b0;
        end
        else
        begin
            iio_rvalid    <= two_word_mode && iio_req.rd;
            ioword_rvalid <= !two_word_mode && ioword_req.rd;
            if (two_word_mode && iio_req.rd)
                iio_rdata <= rd_word;
            if (!two_word_mode && ioword_req.rd)
                ioword_rdata <= rd_word;
        end
    end
endmodule : rtd_data_format_map
`default_nettype wire

// ---- src/rtd_format_pkg.sv ----
package rtd_format_pkg;

    localparam int POINTS     = 8;
    localparam int WORD_W     = 16;
    localparam int ADDR_W     = 7;
    localparam int FIFO_DEPTH = 8;

    // memory map word addresses
    localparam logic [6:0] DATA_BASE_ADDR   = 7'h01;
    localparam logic [6:0] FORMAT_SEL_ADDR  = 7'h18;
    localparam logic [6:0] SCALE_SEL_ADDR   = 7'h1d;
    localparam logic [6:0] STATUS_FLAG_ADDR = 7'h1e;
    localparam logic [6:0] ERROR_FLAG_ADDR  = 7'h1f;
    localparam logic [6:0] PARAM_BASE_ADDR  = 7'h36;

    // reset values
    localparam logic [15:0] FORMAT_SEL_RESET = 16'h0000;
    localparam logic [15:0] SCALE_SEL_RESET  = 16'h0000;
    localparam logic [15:0] PARAM_RESET      = 16'h0001;
    localparam logic [15:0] DATA_RESET       = 16'h0000;

    // error flag bit positions
    localparam int ERR_RO_WRITE  = 0;
    localparam int ERR_NOT_BCD   = 1;
    localparam int ERR_UNMAPPED  = 2;

    // data word limits
    localparam logic signed [19:0] BIN_MAX    = 20'sd32767;
    localparam logic signed [19:0] BIN_MIN    = -20'sd32767;
    localparam logic [13:0]        BCD_MAX    = 14'd7999;
    localparam int                 BCD_SIGN   = 15;

    // sensor types and linearising gains: 16 * 10 / alpha
    localparam logic [1:0]  SENSOR_PT = 2'd0;
    localparam logic [1:0]  SENSOR_NI = 2'd1;
    localparam logic [1:0]  SENSOR_CU = 2'd2;
    localparam logic [16:0] GAIN_PT   = 17'd41558;
    localparam logic [16:0] GAIN_NI   = 17'd23810;
    localparam logic [16:0] GAIN_CU   = 17'd37471;
    localparam int          GAIN_SHIFT = 19;

    // fahrenheit: t*9/5 + 320 tenths, divide by 5 as *52429 >> 18
    localparam logic signed [19:0] F_OFFSET  = 20'sd320;
    localparam logic [16:0]        DIV5_MUL  = 17'd52429;
    localparam int                 DIV5_SHIFT = 18;
    localparam int                 DIV10_SHIFT = 19;

    typedef struct packed {
        logic [2:0]  point;
        logic [1:0]  sensor;
        logic [15:0] delta;
    } conv_sample_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } mm_req_type;

endpackage : rtd_format_pkg

// ---- src/sample_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;
    logic [PW:0]      count_d;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];
    assign out_valid = (count_q != '0);
    assign count_d   = count_q + (PW+1)'(push) - (PW+1)'(pop);

    // ready is a flop so back-pressure reaches the source cleanly
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q     <= '0;
            rd_q     <= '0;
            count_q  <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            count_q  <= count_d;
            in_ready <= (count_d != (PW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
endmodule : sample_fifo
`default_nettype wire

// ---- tb/rtd_data_format_map_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtd_data_format_map_asserts
    import rtd_format_pkg::*;
#(
    parameter int POINT_COUNT = POINTS,
    parameter int FIFO_WORDS  = FIFO_DEPTH
) (
    input wire logic            clk_sys,
    input wire logic            resetn,
    input wire conv_sample_type conv_sample,
    input wire logic            conv_valid,
    input wire logic            conv_ready,
    input wire logic            mode_jumper_upper,
    input wire mm_req_type      iio_req,
    input wire logic [15:0]     iio_rdata,
    input wire logic            iio_rvalid,
    input wire mm_req_type      ioword_req,
    input wire logic [15:0]     ioword_rdata,
    input wire logic            ioword_rvalid,
    input wire logic            two_word_mode
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_iio_rd;
        iio_req.rd && two_word_mode;
    endsequence
    sequence s_io_rd;
        ioword_req.rd && !two_word_mode;
    endsequence
    // six samples cover the three-flop synchroniser plus the mode register
    sequence s_jump_up;
        mode_jumper_upper [*6];
    endsequence
    sequence s_jump_dn;
        !mode_jumper_upper [*6];
    endsequence
    sequence s_scale_rd;
        iio_req.rd && two_word_mode && iio_req.addr == SCALE_SEL_ADDR;
    endsequence
    sequence s_format_rd;
        iio_req.rd && two_word_mode && iio_req.addr == FORMAT_SEL_ADDR;
    endsequence
    sequence s_stray_rd;
        iio_req.rd && two_word_mode && iio_req.addr > 7'h3d;
    endsequence
    a_iio_answer: assert property (s_iio_rd |=> iio_rvalid)
        else $error("iio read not answered");
    a_iio_quiet: assert property (!(iio_req.rd && two_word_mode) |=> !iio_rvalid)
        else $error("iio answer without read");
    a_io_answer: assert property (s_io_rd |=> ioword_rvalid)
        else $error("ioword read not answered");
    a_io_quiet: assert property (!(ioword_req.rd && !two_word_mode) |=> !ioword_rvalid)
        else $error("ioword answer without read");
    a_iio_hold: assert property (!iio_rvalid |-> $stable(iio_rdata))
        else $error("iio data moved without answer");
    a_io_hold: assert property (!ioword_rvalid |-> $stable(ioword_rdata))
        else $error("ioword data moved without answer");
    a_scale_upper: assert property (s_scale_rd |=> iio_rdata[15:8] == 8'h00)
        else $error("scale word upper bits set");
    a_format_upper: assert property (s_format_rd |=> iio_rdata[15:8] == 8'h00)
        else $error("format word upper bits set");
    a_unmapped_zero: assert property (s_stray_rd |=> iio_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_mode_upper: assert property (s_jump_up |-> two_word_mode)
        else $error("upper jumper not 2-word");
    a_mode_lower: assert property (s_jump_dn |-> !two_word_mode)
        else $error("lower jumper not 4-word");
endmodule : rtd_data_format_map_asserts
bind rtd_data_format_map rtd_data_format_map_asserts #(
    .POINT_COUNT(POINT_COUNT),
    .FIFO_WORDS(FIFO_WORDS)
) i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .conv_sample(conv_sample),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .mode_jumper_upper(mode_jumper_upper),
    .iio_req(iio_req), .iio_rdata(iio_rdata), .iio_rvalid(iio_rvalid),
    .ioword_req(ioword_req), .ioword_rdata(ioword_rdata), .ioword_rvalid(ioword_rvalid),
    .two_word_mode(two_word_mode)
);
`default_nettype wire

// ---- tb/conv_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module conv_source
    import rtd_format_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      conv_ready,
    output var  conv_sample_type conv_sample,
    output var  logic      conv_valid
);
    initial
    begin
        conv_sample = '0;
        conv_valid  = 1'b0;
    end
    // valid stays up between samples so back-to-back sends never toggle it twice
    task automatic send(input logic [2:0] pt, input logic [1:0] sn, input logic [15:0] dl);
        conv_sample = '{point: pt, sensor: sn, delta: dl};
        conv_valid  = 1'b1;
        @(posedge clk_sys);
        while (conv_ready !== 1'b1)
            @(posedge clk_sys);
        #1;
    endtask : send
    // released lines show the inverse so a stale sample never passes for a new one
    task automatic idle();
        conv_valid  = 1'b0;
        conv_sample = ~conv_sample;
    endtask : idle
endmodule : conv_source
`default_nettype wire

// ---- tb/test_rtd_data_format_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rtd_data_format_map;
    import rtd_format_pkg::*;
    logic            clk_sys = 1'b0;
    logic            resetn  = 1'b0;
    logic            jumper  = 1'b1;
    logic            sel     = 1'b0;
    logic            full    = 1'b0;
    mm_req_type      req     = '0;
    conv_sample_type smp;
    logic            cv, crdy, twm, iv, ov;
    logic [15:0]     ird, ord;
    int              err_total = 0;
    int              n_checks  = 0;
    localparam logic [1:0]  SN [7] = '{SENSOR_PT, SENSOR_PT, SENSOR_PT, SENSOR_NI, SENSOR_CU, SENSOR_PT, SENSOR_PT};
    localparam logic [15:0] DL [7] = '{16'h1000, 16'h1000, 16'hf000, 16'h1000, 16'h1000, 16'h1000, 16'hf000};
    localparam logic [15:0] EXP [7] = '{16'h0032, 16'h0144, 16'h8033, 16'h00ba, 16'h0124, 16'h0387, 16'hfebb};

    rtd_data_format_map i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .conv_sample(smp), .conv_valid(cv),
        .conv_ready(crdy), .mode_jumper_upper(jumper), .iio_req(req), .iio_rdata(ird),
        .iio_rvalid(iv), .ioword_req(req), .ioword_rdata(ord), .ioword_rvalid(ov),
        .two_word_mode(twm)
    );
    conv_source i_src (.clk_sys(clk_sys), .conv_ready(crdy), .conv_sample(smp), .conv_valid(cv));

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // both ports see every request; the one of the other mode must stay silent
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        #1;
        req = '{1'b1, 1'b0, a, 16'h0000};
        @(posedge clk_sys);
        #1;
        req = '0;
        chk(sel ? ord : ird, e);
        chk({14'h0, iv, ov}, sel ? 16'h0001 : 16'h0002);
    endtask : rdc

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        req = '{1'b0, 1'b1, a, d};
        @(posedge clk_sys);
        #1;
        req = '0;
    endtask : wr

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        end_of_test();
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        chk({14'h0, crdy, twm}, 16'h0003);
        rdc(FORMAT_SEL_ADDR, FORMAT_SEL_RESET);
        rdc(SCALE_SEL_ADDR, SCALE_SEL_RESET);
        rdc(STATUS_FLAG_ADDR, 16'h0000);
        rdc(ERROR_FLAG_ADDR, 16'h0000);
        rdc(DATA_BASE_ADDR, DATA_RESET);
        rdc(PARAM_BASE_ADDR, PARAM_RESET);
        wr(FORMAT_SEL_ADDR, 16'hff7a);
        rdc(FORMAT_SEL_ADDR, 16'h007a);
        wr(SCALE_SEL_ADDR, 16'h0020);
        rdc(SCALE_SEL_ADDR, 16'h0020);
        for (int i = 0; i < 7; i++)
            i_src.send(3'(i), SN[i], DL[i]);
        i_src.idle();
        // generous margin over the four-cycle conversion pipeline
        repeat (40) @(posedge clk_sys);
        rdc(STATUS_FLAG_ADDR, 16'h7f7a);
        for (int i = 0; i < 7; i++)
            rdc(DATA_BASE_ADDR + 7'(i), EXP[i]);
        rdc(STATUS_FLAG_ADDR, 16'h007a);
        wr(DATA_BASE_ADDR, 16'h1234);
        rdc(DATA_BASE_ADDR, 16'h0032);
        wr(PARAM_BASE_ADDR, 16'h00a0);
        rdc(PARAM_BASE_ADDR, PARAM_RESET);
        wr(PARAM_BASE_ADDR + 7'h1, 16'h1234);
        rdc(PARAM_BASE_ADDR + 7'h1, 16'h1234);
        rdc(7'h50, 16'h0000);
        rdc(ERROR_FLAG_ADDR, 16'h0007);
        rdc(ERROR_FLAG_ADDR, 16'h0000);
        // reads held back to back stall the pop, so the buffer must fill and push back
        fork
            begin
                for (int i = 0; i < 10; i++)
                    i_src.send(3'd7, SENSOR_PT, 16'h1000);
                i_src.idle();
            end
            begin
                @(posedge clk_sys);
                #1;
                req = '{1'b1, 1'b0, SCALE_SEL_ADDR, 16'h0000};
                repeat (24)
                begin
                    @(posedge clk_sys);
                    #1;
                    if (crdy === 1'b0)
                        full = 1'b1;
                end
                req = '0;
            end
        join
        chk({15'h0, full}, 16'h0001);
        repeat (80) @(posedge clk_sys);
        rdc(DATA_BASE_ADDR + 7'h7, 16'h0032);
        jumper = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({15'h0, twm}, 16'h0000);
        sel = 1'b1;
        rdc(SCALE_SEL_ADDR, 16'h0020);
        wr(SCALE_SEL_ADDR, 16'h0001);
        rdc(SCALE_SEL_ADDR, 16'h0001);
        rdc(7'h50, 16'h0000);
        end_of_test();
    end
endmodule : test_rtd_data_format_map
`default_nettype wire
